// *** src/rlce_addr_resolve.sv ***
// operand address resolution: access bank, banked or indexed literal offset
`timescale 1ns/1ps
`default_nettype none
module rlce_addr_resolve #(
    parameter int BANK_W = 4
) (
    input wire logic [7:0] f_field, // 8-bit address field of the opcode
    input wire logic bank_sel, // bank-select operand bit
    input wire logic ext_en, // extended instruction set active
    input wire logic [BANK_W-1:0] bank_select_reg, // current bank
    input wire logic [BANK_W+7:0] index_base, // base for indexed offset
    output logic [BANK_W+7:0] eff_addr, // resolved data address
    output rlce_pkg::rlce_mode_type mode // which addressing was used
);
    localparam int ADDR_W = BANK_W + 8;

    always_comb
    begin
        eff_addr = {{BANK_W{1'b0}}, f_field};
        mode = rlce_pkg::AM_ACCESS;
        if (bank_sel)
        begin
            eff_addr = {bank_select_reg, f_field};
            mode = rlce_pkg::AM_BANKED;
        end
        else if (ext_en && (f_field <= rlce_pkg::ILO_LIMIT))
        begin
            // wraps at the top of data space, like the base pointer does
            eff_addr = index_base + {{BANK_W{1'b0}}, f_field};
            mode = rlce_pkg::AM_INDEXED;
        end
        else if (f_field < rlce_pkg::ACCESS_SPLIT)
        begin
            eff_addr = {{BANK_W{1'b0}}, f_field};
        end
        else
        begin
            // upper part of the access bank is the top bank
            eff_addr = {{BANK_W{1'b1}}, f_field};
        end
    end

    if (ADDR_W > 15)
    begin : g_bad_width
        $error("rlce_addr_resolve: BANK_W too large");
    end
endmodule : rlce_addr_resolve
`default_nettype wire

// *** src/rlce_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module rlce_exec #(
    parameter int BANK_W = 4
) (
    input wire logic sys_clk, // core clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [rlce_pkg::BUS_AW-1:0] reg_addr, // register index
    input wire logic [rlce_pkg::BUS_DW-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [rlce_pkg::BUS_DW-1:0] reg_rdata, // read data, next cycle
    output logic busy, // instruction in flight
    output logic done, // pulse at end of the write phase
    output logic flag_update, // pulse when the instruction writes C, N, Z
    output logic dest_file, // last destination was the file register
    output logic [BANK_W+7:0] operand_addr // resolved operand address
);
    localparam int ADDR_W = BANK_W + 8;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int DW = rlce_pkg::DATA_W;
    localparam int PAD_A = rlce_pkg::BUS_DW - ADDR_W;
    localparam int PAD_D = rlce_pkg::BUS_DW - DW;
    localparam int PAD_S = rlce_pkg::BUS_DW - rlce_pkg::ST_W;
    localparam int PAD_B = rlce_pkg::BUS_DW - BANK_W;

    if (BANK_W < 1 || BANK_W > 7)
    begin : g_bad_bank
        $error("rlce_exec: BANK_W must be 1 to 7");
    end

    // data memory of the core
    logic [DW-1:0] general_purpose_ram [0:DEPTH-1];
    logic ram_we;
    logic [ADDR_W-1:0] ram_waddr;
    logic [DW-1:0] ram_wdata;

    rlce_pkg::rlce_phase_type phase_r, phase_nxt;
    rlce_pkg::rlce_mode_type mode_r, mode_nxt;
    rlce_pkg::rlce_mode_type res_mode;
    logic ext_en_r, ext_en_nxt;
    logic [BANK_W-1:0] bank_select_reg_r, bank_select_reg_nxt;
    logic [DW-1:0] wreg_r, wreg_nxt;
    logic flag_c_r, flag_c_nxt;
    logic flag_z_r, flag_z_nxt;
    logic flag_n_r, flag_n_nxt;
    logic bad_op_r, bad_op_nxt;
    logic [ADDR_W-1:0] index_base_r, index_base_nxt;
    logic [ADDR_W-1:0] ram_addr_r, ram_addr_nxt;
    logic [rlce_pkg::OPC_W-1:0] opcode_r, opcode_nxt;
    logic dest_r, dest_nxt;
    logic [ADDR_W-1:0] ea_r, ea_nxt;
    logic [DW-1:0] operand_r, operand_nxt;
    logic [DW-1:0] result_r, result_nxt;
    logic res_c_r, res_c_nxt;
    logic res_n_r, res_n_nxt;
    logic res_z_r, res_z_nxt;
    logic [rlce_pkg::BUS_DW-1:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic flag_upd_r, flag_upd_nxt;
    logic dest_file_r, dest_file_nxt;
    logic [ADDR_W-1:0] res_addr;
    logic [DW-1:0] rot_result;
    logic rot_c;
    logic rot_n;
    logic rot_z;
    logic idle;
    logic sw_wr;
    logic [rlce_pkg::ST_W-1:0] status_word;

    rlce_addr_resolve #(
        .BANK_W(BANK_W)
    ) u_resolve (
        .f_field(opcode_r[DW-1:0]),
        .bank_sel(opcode_r[rlce_pkg::OPC_A_BIT]),
        .ext_en(ext_en_r),
        .bank_select_reg(bank_select_reg_r),
        .index_base(index_base_r),
        .eff_addr(res_addr),
        .mode(res_mode)
    );

    rlce_rotate u_rotate (
        .operand(operand_r),
        .carry_in(flag_c_r),
        .result(rot_result),
        .carry_out(rot_c),
        .negative(rot_n),
        .zero(rot_z)
    );

    assign idle = (phase_r == rlce_pkg::PH_IDLE);
    // software writes are dropped while an instruction runs
    assign sw_wr = reg_wr && idle;
    assign status_word = {bad_op_r, !idle, flag_n_r, flag_z_r, flag_c_r};

    always_comb
    begin
        phase_nxt = phase_r;
        mode_nxt = mode_r;
        ext_en_nxt = ext_en_r;
        bank_select_reg_nxt = bank_select_reg_r;
        wreg_nxt = wreg_r;
        flag_c_nxt = flag_c_r;
        flag_z_nxt = flag_z_r;
        flag_n_nxt = flag_n_r;
        bad_op_nxt = bad_op_r;
        index_base_nxt = index_base_r;
        ram_addr_nxt = ram_addr_r;
        opcode_nxt = opcode_r;
        dest_nxt = dest_r;
        ea_nxt = ea_r;
        operand_nxt = operand_r;
        result_nxt = result_r;
        res_c_nxt = res_c_r;
        res_n_nxt = res_n_r;
        res_z_nxt = res_z_r;
        done_nxt = 1'b0;
        flag_upd_nxt = 1'b0;
        dest_file_nxt = dest_file_r;
        ram_we = 1'b0;
        ram_waddr = ram_addr_r;
        ram_wdata = reg_wdata[DW-1:0];

        if (sw_wr)
        begin
            case (reg_addr)
                rlce_pkg::REG_CTRL:
                    ext_en_nxt = reg_wdata[rlce_pkg::CTRL_EXT_BIT];
                rlce_pkg::REG_BANK:
                    bank_select_reg_nxt = reg_wdata[BANK_W-1:0];
                rlce_pkg::REG_WREG:
                    wreg_nxt = reg_wdata[DW-1:0];
                rlce_pkg::REG_STATUS:
                begin
                    flag_c_nxt = reg_wdata[rlce_pkg::ST_C];
                    flag_z_nxt = reg_wdata[rlce_pkg::ST_Z];
                    flag_n_nxt = reg_wdata[rlce_pkg::ST_N];
                    if (reg_wdata[rlce_pkg::ST_BAD])
                    begin
                        bad_op_nxt = 1'b0;
                    end
                end
                rlce_pkg::REG_INDEX_BASE:
                    index_base_nxt = reg_wdata[ADDR_W-1:0];
                rlce_pkg::REG_RAM_ADDR:
                    ram_addr_nxt = reg_wdata[ADDR_W-1:0];
                rlce_pkg::REG_RAM_DATA:
                    ram_we = 1'b1;
                rlce_pkg::REG_INSTR:
                begin
                    opcode_nxt = reg_wdata;
                    if (reg_wdata[rlce_pkg::OPC_W-1:rlce_pkg::OPC_PREFIX_LSB]
                        == rlce_pkg::OPC_PREFIX)
                    begin
                        phase_nxt = rlce_pkg::PH_DECODE;
                    end
                    else
                    begin
                        // foreign opcode: not ours to run, left to the core
                        bad_op_nxt = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        case (phase_r)
            rlce_pkg::PH_IDLE:
            begin
            end
            rlce_pkg::PH_DECODE:
            begin
                dest_nxt = opcode_r[rlce_pkg::OPC_D_BIT];
                ea_nxt = res_addr;
                mode_nxt = res_mode;
                phase_nxt = rlce_pkg::PH_READ;
            end
            rlce_pkg::PH_READ:
            begin
                operand_nxt = general_purpose_ram[ea_r];
                phase_nxt = rlce_pkg::PH_PROCESS;
            end
            rlce_pkg::PH_PROCESS:
            begin
                result_nxt = rot_result;
                res_c_nxt = rot_c;
                res_n_nxt = rot_n;
                res_z_nxt = rot_z;
                phase_nxt = rlce_pkg::PH_WRITE;
            end
            rlce_pkg::PH_WRITE:
            begin
                if (dest_r)
                begin
                    ram_we = 1'b1;
                    ram_waddr = ea_r;
                    ram_wdata = result_r;
                end
                else
                begin
                    wreg_nxt = result_r;
                end
                flag_c_nxt = res_c_r;
                flag_n_nxt = res_n_r;
                flag_z_nxt = res_z_r;
                flag_upd_nxt = 1'b1;
                dest_file_nxt = dest_r;
                done_nxt = 1'b1;
                phase_nxt = rlce_pkg::PH_IDLE;
            end
            default:
                phase_nxt = rlce_pkg::PH_IDLE;
        endcase
    end

    always_comb
    begin
        rdata_nxt = rlce_pkg::BUS_ZERO;
        if (reg_rd)
        begin
            case (reg_addr)
                rlce_pkg::REG_CTRL:
                    rdata_nxt = {{(rlce_pkg::BUS_DW-1){1'b0}}, ext_en_r};
                rlce_pkg::REG_BANK:
                    rdata_nxt = {{PAD_B{1'b0}}, bank_select_reg_r};
                rlce_pkg::REG_WREG:
                    rdata_nxt = {{PAD_D{1'b0}}, wreg_r};
                rlce_pkg::REG_STATUS:
                    rdata_nxt = {{PAD_S{1'b0}}, status_word};
                rlce_pkg::REG_INDEX_BASE:
                    rdata_nxt = {{PAD_A{1'b0}}, index_base_r};
                rlce_pkg::REG_RAM_ADDR:
                    rdata_nxt = {{PAD_A{1'b0}}, ram_addr_r};
                rlce_pkg::REG_RAM_DATA:
                    rdata_nxt = {{PAD_D{1'b0}}, general_purpose_ram[ram_addr_r]};
                rlce_pkg::REG_INSTR:
                    rdata_nxt = opcode_r;
                rlce_pkg::REG_LAST_ADDR:
                    rdata_nxt = {{PAD_A{1'b0}}, ea_r};
                default:
                    rdata_nxt = rlce_pkg::BUS_ZERO;
            endcase
        end
    end

    // memory contents are not reset; software loads what it needs
    always_ff @(posedge sys_clk)
    begin
        if (ram_we)
        begin
            general_purpose_ram[ram_waddr] <= ram_wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            phase_r <= rlce_pkg::PH_IDLE;
            mode_r <= rlce_pkg::AM_ACCESS;
            ext_en_r <= 1'b0;
            bank_select_reg_r <= '0;
            wreg_r <= rlce_pkg::DATA_RST;
            flag_c_r <= 1'b0;
            flag_z_r <= 1'b0;
            flag_n_r <= 1'b0;
            bad_op_r <= 1'b0;
            index_base_r <= '0;
            ram_addr_r <= '0;
            opcode_r <= rlce_pkg::BUS_ZERO;
            dest_r <= 1'b0;
            ea_r <= '0;
            operand_r <= rlce_pkg::DATA_RST;
            result_r <= rlce_pkg::DATA_RST;
            res_c_r <= 1'b0;
            res_n_r <= 1'b0;
            res_z_r <= 1'b0;
            rdata_r <= rlce_pkg::BUS_ZERO;
            done_r <= 1'b0;
            flag_upd_r <= 1'b0;
            dest_file_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            mode_r <= mode_nxt;
            ext_en_r <= ext_en_nxt;
            bank_select_reg_r <= bank_select_reg_nxt;
            wreg_r <= wreg_nxt;
            flag_c_r <= flag_c_nxt;
            flag_z_r <= flag_z_nxt;
            flag_n_r <= flag_n_nxt;
            bad_op_r <= bad_op_nxt;
            index_base_r <= index_base_nxt;
            ram_addr_r <= ram_addr_nxt;
            opcode_r <= opcode_nxt;
            dest_r <= dest_nxt;
            ea_r <= ea_nxt;
            operand_r <= operand_nxt;
            result_r <= result_nxt;
            res_c_r <= res_c_nxt;
            res_n_r <= res_n_nxt;
            res_z_r <= res_z_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            flag_upd_r <= flag_upd_nxt;
            dest_file_r <= dest_file_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign busy = !idle;
    assign done = done_r;
    assign flag_update = flag_upd_r;
    assign dest_file = dest_file_r;
    assign operand_addr = ea_r;
endmodule : rlce_exec
`default_nettype wire

// *** src/rlce_pkg.sv ***
// constants and types shared by the rotate-left-through-carry datapath
package rlce_pkg;
    localparam int DATA_W = 8;
    localparam int BUS_AW = 4;
    localparam int BUS_DW = 16;
    localparam int OPC_W = 16;
    localparam int OPC_PREFIX_W = 6;
    localparam int OPC_PREFIX_LSB = 10;
    localparam int OPC_D_BIT = 9;
    localparam int OPC_A_BIT = 8;
    localparam logic [OPC_PREFIX_W-1:0] OPC_PREFIX = 6'h0d;
    localparam logic [BUS_AW-1:0] REG_CTRL = 4'h0;
    localparam logic [BUS_AW-1:0] REG_BANK = 4'h1;
    localparam logic [BUS_AW-1:0] REG_WREG = 4'h2;
    localparam logic [BUS_AW-1:0] REG_STATUS = 4'h3;
    localparam logic [BUS_AW-1:0] REG_INDEX_BASE = 4'h4;
    localparam logic [BUS_AW-1:0] REG_RAM_ADDR = 4'h5;
    localparam logic [BUS_AW-1:0] REG_RAM_DATA = 4'h6;
    localparam logic [BUS_AW-1:0] REG_INSTR = 4'h7;
    localparam logic [BUS_AW-1:0] REG_LAST_ADDR = 4'h8;
    localparam int CTRL_EXT_BIT = 0;
    localparam int ST_C = 0;
    localparam int ST_Z = 1;
    localparam int ST_N = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_BAD = 4;
    localparam int ST_W = 5;
    localparam logic [DATA_W-1:0] ILO_LIMIT = 8'h5f;
    localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h60;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [BUS_DW-1:0] BUS_ZERO = 16'h0000;
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } rlce_phase_type;
    typedef enum logic [1:0] {
        AM_ACCESS,
        AM_BANKED,
        AM_INDEXED
    } rlce_mode_type;
endpackage : rlce_pkg

// *** src/rlce_rotate.sv ***
// rotate one byte left through carry and derive the flags
`timescale 1ns/1ps
`default_nettype none
module rlce_rotate (
    input wire logic [7:0] operand, // value read from the file register
    input wire logic carry_in, // carry flag before the instruction
    output logic [7:0] result, // rotated value
    output logic carry_out, // displaced top bit
    output logic negative, // top bit of result
    output logic zero // result is all zeros
);
    always_comb
    begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
        negative = result[7];
        zero = (result == rlce_pkg::DATA_RST);
    end
endmodule : rlce_rotate
`default_nettype wire

// *** testbench/rlce_exec_props.sv ***
// port-level checker for the rotate-left-through-carry datapath
`timescale 1ns/1ps
`default_nettype none
module rlce_exec_props #(
    parameter int BANK_W = 4
) (
    input wire logic sys_clk, // core clock
    input wire logic rst, // synchronous reset
    input wire logic [rlce_pkg::BUS_AW-1:0] reg_addr, // register index
    input wire logic [rlce_pkg::BUS_DW-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [rlce_pkg::BUS_DW-1:0] reg_rdata, // read data
    input wire logic busy, // instruction in flight
    input wire logic done, // end of write phase
    input wire logic flag_update, // flags written
    input wire logic dest_file, // last destination
    input wire logic [BANK_W+7:0] operand_addr // resolved address
);
    // shadow of the registers that steer address resolution
    logic [BANK_W-1:0] bank_r, bank_nxt;
    logic ext_r, ext_nxt;
    logic [BANK_W+7:0] ib_r, ib_nxt;
    logic a_w;
    logic [7:0] f_w;
    assign a_w = reg_wdata[rlce_pkg::OPC_A_BIT];
    assign f_w = reg_wdata[7:0];
    always_comb
    begin
        bank_nxt = bank_r;
        ext_nxt = ext_r;
        ib_nxt = ib_r;
        // writes while busy are dropped by the design, so ignore them too
        if (reg_wr && !busy)
        begin
            if (reg_addr == rlce_pkg::REG_BANK)
                bank_nxt = reg_wdata[BANK_W-1:0];
            if (reg_addr == rlce_pkg::REG_CTRL)
                ext_nxt = reg_wdata[rlce_pkg::CTRL_EXT_BIT];
            if (reg_addr == rlce_pkg::REG_INDEX_BASE)
                ib_nxt = reg_wdata[BANK_W+7:0];
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bank_r <= '0;
            ext_r <= 1'b0;
            ib_r <= '0;
        end
        else
        begin
            bank_r <= bank_nxt;
            ext_r <= ext_nxt;
            ib_r <= ib_nxt;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_instr_wr;
        reg_wr && !busy && reg_addr == rlce_pkg::REG_INSTR;
    endsequence
    sequence s_launch;
        s_instr_wr ##0 reg_wdata[15:10] == rlce_pkg::OPC_PREFIX;
    endsequence
    sequence s_run;
        busy [*4] ##1 (done && flag_update && !busy);
    endsequence
    property p_dest;
        logic d;
        (s_launch, d = reg_wdata[rlce_pkg::OPC_D_BIT]) |-> ##5 dest_file == d;
    endproperty
    property p_banked;
        logic [BANK_W+7:0] ea;
        (s_launch ##0 a_w, ea = {bank_r, f_w}) |-> ##2 operand_addr == ea;
    endproperty
    property p_access;
        logic [BANK_W+7:0] ea;
        (s_launch ##0 (!a_w && !(ext_r && f_w <= rlce_pkg::ILO_LIMIT)),
            ea = {{BANK_W{f_w >= rlce_pkg::ACCESS_SPLIT}}, f_w})
            |-> ##2 operand_addr == ea;
    endproperty
    property p_indexed;
        logic [BANK_W+7:0] ea;
        (s_launch ##0 (!a_w && ext_r && f_w <= rlce_pkg::ILO_LIMIT),
            ea = ib_r + {{BANK_W{1'b0}}, f_w}) |-> ##2 operand_addr == ea;
    endproperty
    AST_RUN_FOUR_PHASES:
        assert property (s_launch |=> s_run)
        else $error("instruction did not run four phases then finish");
    AST_BAD_OPCODE_NO_RUN:
        assert property ((s_instr_wr ##0 reg_wdata[15:10] != 6'h0d)
            |=> !busy ##4 !done)
        else $error("foreign opcode started a run");
    AST_FLAGS_WITH_DONE:
        assert property (done |-> flag_update && $past(busy))
        else $error("done without flag update after busy");
    AST_DEST_SELECT:
        assert property (p_dest) else $error("destination flag wrong");
    AST_BANKED_ADDR:
        assert property (p_banked) else $error("banked address wrong");
    AST_ACCESS_ADDR:
        assert property (p_access) else $error("access bank address wrong");
    AST_INDEXED_ADDR:
        assert property (p_indexed) else $error("indexed address wrong");
endmodule : rlce_exec_props
`default_nettype wire

// *** testbench/rlce_exec_tb_top.sv ***
// self-checking testbench for the rotate-left-through-carry datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
    begin \
        n_compared++; \
        if ((gt) !== (ex)) \
        begin \
            err_total++; \
            $display("ERROR %s expected %h seen %h", nm, ex, gt); \
        end \
    end
module rlce_exec_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic busy, done, flag_update, dest_file;
    logic [11:0] operand_addr;
    int err_total = 0;
    int n_compared = 0;
    always #10 sys_clk = ~sys_clk;
    rlce_exec #(.BANK_W(4)) dut (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .done(done),
        .flag_update(flag_update), .dest_file(dest_file),
        .operand_addr(operand_addr));
    task automatic results();
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    function automatic logic [11:0] ea_f(input logic ext, input logic a,
        input logic [3:0] bank, input logic [11:0] ib, input logic [7:0] f);
        if (a)
            return {bank, f};
        if (ext && f <= 8'h5f)
            return ib + {4'h0, f};
        return {{4{f >= 8'h60}}, f};
    endfunction : ea_f
    task automatic test(input logic ext, input logic a, input logic d,
        input logic [7:0] f, input logic [7:0] op, input logic c);
        logic [3:0] bank;
        logic [11:0] ib, ea;
        logic [7:0] w, r;
        logic [15:0] v;
        int i;
        bank = 4'($urandom);
        ib = 12'($urandom);
        w = 8'($urandom);
        r = {op[6:0], c};
        ea = ea_f(ext, a, bank, ib, f);
        wr(rlce_pkg::REG_CTRL, {15'h0000, ext});
        wr(rlce_pkg::REG_BANK, {12'h000, bank});
        wr(rlce_pkg::REG_INDEX_BASE, {4'h0, ib});
        wr(rlce_pkg::REG_STATUS, {15'h0008, c});
        wr(rlce_pkg::REG_WREG, {8'h00, w});
        wr(rlce_pkg::REG_RAM_ADDR, {4'h0, ea});
        wr(rlce_pkg::REG_RAM_DATA, {8'h00, op});
        wr(rlce_pkg::REG_INSTR, {6'h0d, d, a, f});
        for (i = 1; i < 10 && done !== 1'b1; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        `CHK("done cycle", 5, i)
        `CHK("flag_update", 1'b1, flag_update)
        `CHK("dest_file", d, dest_file)
        `CHK("busy at done", 1'b0, busy)
        `CHK("operand_addr port", ea, operand_addr)
        rd(rlce_pkg::REG_LAST_ADDR, v);
        `CHK("operand addr", {4'h0, ea}, v)
        rd(rlce_pkg::REG_STATUS, v);
        `CHK("status", {13'h0000, r[7], r == 8'h00, op[7]}, v)
        rd(rlce_pkg::REG_WREG, v);
        `CHK("wreg", {8'h00, d ? w : r}, v)
        rd(rlce_pkg::REG_RAM_DATA, v);
        `CHK("file reg", {8'h00, d ? r : op}, v)
    endtask : test
    initial
    begin
        logic [31:0] x;
        logic [15:0] v;
        void'($urandom(32'hd1ec));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        // indexed limit, zero result with carry out
        test(1'b1, 1'b0, 1'b1, 8'h5f, 8'h80, 1'b0);
        // first address past the indexed window lands in the top bank
        test(1'b1, 1'b0, 1'b0, 8'h60, 8'h7f, 1'b1);
        test(1'b0, 1'b0, 1'b1, 8'h10, 8'h00, 1'b0);
        test(1'b0, 1'b1, 1'b0, 8'hff, 8'hff, 1'b1);
        wr(rlce_pkg::REG_INSTR, 16'h3dff);
        rd(rlce_pkg::REG_STATUS, v);
        `CHK("bad opcode flag", 2'b10, v[4:3])
        repeat (40)
        begin
            x = $urandom;
            test(x[0], x[1], x[2], x[15:8], x[23:16], x[3]);
        end
        // a write that lands during a run must be dropped
        wr(rlce_pkg::REG_WREG, 16'h005a);
        wr(rlce_pkg::REG_INSTR, {6'h0d, 2'b10, 8'h20});
        wr(rlce_pkg::REG_WREG, 16'h00a5);
        rd(rlce_pkg::REG_WREG, v);
        `CHK("wreg write while busy", 16'h005a, v)
        rd(rlce_pkg::REG_INSTR, v);
        `CHK("opcode readback", {6'h0d, 2'b10, 8'h20}, v)
        // reset arrives one cycle into a second run
        wr(rlce_pkg::REG_INSTR, {6'h0d, 2'b11, 8'h20});
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK("busy after reset", 1'b0, busy)
        `CHK("done after reset", 1'b0, done)
        `CHK("addr after reset", 12'h000, operand_addr)
        rd(rlce_pkg::REG_STATUS, v);
        `CHK("status after reset", 16'h0000, v)
        rd(rlce_pkg::REG_CTRL, v);
        `CHK("ctrl after reset", 16'h0000, v)
        results();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        results();
    end
endmodule : rlce_exec_tb_top
bind rlce_exec rlce_exec_props #(.BANK_W(BANK_W)) u_props (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .busy(busy), .done(done),
    .flag_update(flag_update), .dest_file(dest_file),
    .operand_addr(operand_addr));
`default_nettype wire
